// ### rtl/pmq_count_qualifier.sv
/*
  Per-thread count enable, qualification and 48-bit event counters
  for the performance monitor, with an APB register slave.
  Assumes core-side inputs are on clk and need no synchroniser.
*/
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps

// Operation
// [RQ1] each monitor counts only if its privilege mask bit at current level is set
// [RQ2] select bit 0 makes a user monitor, gated by global user enable
// [RQ3] select bit 1 makes a system monitor, gated by global system enable
// [RQ4] interruption delivery loads system enable from the default control copy
// [RQ5] set and reset user mask instructions change the user enable
// [RQ6] system enable changes only at level 0 via set/reset system mask; the code also reloads it on interruption delivery at any level
// [RQ7] each monitor has a two-bit virtual state mask gating counting
// [RQ8] count-halted bit keeps a monitor counting while the core is halted
// [RQ9] sixteen 48-bit counters, configuration and data at indices 4 to 19
// [RQ10] indices 0 to 3 hold overflow and freeze status, no data
// [RQ11] every monitor register and feature exists once per hardware thread
// [RQ12] qualification uses the state of the thread raising the event
// [RQ13] software programs both threads' range and type qualifiers alike
// [RQ14] no qualification by instruction set is offered
// [RQ15] events may be limited to an instruction address range
// [RQ16] two opcode mask and match sets plus one opcode configuration
// [RQ17] memory events further qualified by data range and reference type
// [RQ18] virtual match is mask bit at current state, or mask all zero
// [RQ19] count needs no freeze, privilege, virtual, enable and halt terms
// [RQ20] overflow or software sets freeze; counting stops until cleared
module pmq_count_qualifier
  import pmq_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire pmq_thr_in_t [THREADS-1:0] thrIn,
  input wire logic [THREADS-1:0][MONS-1:0] events,
  output logic [THREADS-1:0][MONS-1:0] countEnable
);

  // one full copy of the monitor state per thread, see [RQ11]
  pmq_mon_cfg_t [THREADS-1:0][MONS-1:0] cfg_reg, cfg_next;
  logic [THREADS-1:0][MONS-1:0][CNT_W-1:0] cnt_reg, cnt_next;
  logic [THREADS-1:0][MONS-1:0] ovf_reg, ovf_next;
  logic [THREADS-1:0] freeze_reg, freeze_next;
  logic [THREADS-1:0] up_reg, up_next;
  logic [THREADS-1:0] pp_reg, pp_next;
  logic [THREADS-1:0] defPp_reg, defPp_next;
  logic [THREADS-1:0][1:0][OPC_W-1:0] opmMask_reg, opmMask_next;
  logic [THREADS-1:0][1:0][OPC_W-1:0] opmMatch_reg, opmMatch_next;
  logic [THREADS-1:0] iamEn_reg, iamEn_next;
  logic [THREADS-1:0][1:0] opmEn_reg, opmEn_next;
  logic [THREADS-1:0] damAddrEn_reg, damAddrEn_next;
  logic [THREADS-1:0][3:0] damType_reg, damType_next;
  logic [THREADS-1:0][MONS-1:0] countEnable_next;
  logic pready_reg, pready_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;

  logic [8:0] wordIdx;
  logic selThr;
  logic addrOk;
  logic wrEn;
  logic [31:0] rdVal;
  logic [4:0] cfgSlot;
  logic [4:0] dataSlot;
  logic dataHi;

  assign wordIdx = paddr[10:2];
  assign selThr = paddr[THREAD_BIT];
  assign cfgSlot = 5'(wordIdx - IDX_CFG_FIRST);
  assign dataSlot = 5'((wordIdx - IDX_DATA_BASE) >> 1);
  assign dataHi = wordIdx[0];

  // address decode and read mux
  always_comb begin
    addrOk = 1'b1;
    rdVal = WORD_RESET;
    if (paddr[1:0] != 2'b00) begin
      addrOk = 1'b0;
    end else if (wordIdx == IDX_STATUS0) begin // see [RQ10]
      rdVal[STAT_FREEZE_BIT] = freeze_reg[selThr];
      rdVal[STAT_OVF_LSB +: MONS] = ovf_reg[selThr];
    end else if (wordIdx <= IDX_STATUS3) begin
      rdVal = WORD_RESET;
    end else if (wordIdx <= IDX_CFG_LAST) begin // see [RQ9]
      rdVal[CFG_PLM_LSB +: 4] =
        cfg_reg[selThr][cfgSlot[3:0]].privilegeLevelMask;
      rdVal[CFG_PM_BIT] = cfg_reg[selThr][cfgSlot[3:0]].systemMonitorSelect;
      rdVal[CFG_VM_LSB +: 2] = cfg_reg[selThr][cfgSlot[3:0]].virtStateMask;
      rdVal[CFG_CH_BIT] =
        cfg_reg[selThr][cfgSlot[3:0]].countHaltedQualifier;
      rdVal[CFG_QUAL_BIT] = cfg_reg[selThr][cfgSlot[3:0]].qual;
      rdVal[CFG_OPM_SEL_BIT] = cfg_reg[selThr][cfgSlot[3:0]].opmSel;
    end else if (wordIdx == IDX_OPM0_MSK) begin
      rdVal = opmMask_reg[selThr][0];
    end else if (wordIdx == IDX_OPM0_MAT) begin
      rdVal = opmMatch_reg[selThr][0];
    end else if (wordIdx == IDX_OPM1_MSK) begin
      rdVal = opmMask_reg[selThr][1];
    end else if (wordIdx == IDX_OPM1_MAT) begin
      rdVal = opmMatch_reg[selThr][1];
    end else if (wordIdx == IDX_IAM_CFG) begin
      rdVal[IAM_EN_BIT] = iamEn_reg[selThr];
    end else if (wordIdx == IDX_OPM_CFG) begin
      rdVal[OPM_EN0_BIT] = opmEn_reg[selThr][0];
      rdVal[OPM_EN1_BIT] = opmEn_reg[selThr][1];
    end else if (wordIdx == IDX_DAM_CFG) begin
      rdVal[DAM_ADDR_EN_BIT] = damAddrEn_reg[selThr];
      rdVal[DAM_TYPE_LSB +: 4] = damType_reg[selThr];
    end else if (wordIdx == IDX_PROC_STATUS) begin
      rdVal[PS_UP_BIT] = up_reg[selThr];
      rdVal[PS_PP_BIT] = pp_reg[selThr];
    end else if (wordIdx == IDX_DEF_CTRL) begin
      rdVal[DEF_PP_BIT] = defPp_reg[selThr];
    end else if (wordIdx >= IDX_DATA_BASE + 9'(2 * FIRST_CNT_IDX) &&
                 wordIdx <= IDX_DATA_LAST) begin
      if (dataHi) begin
        rdVal[CNT_HI_W-1:0] =
          cnt_reg[selThr][4'(dataSlot - 5'(FIRST_CNT_IDX))][CNT_W-1:32];
      end else begin
        rdVal = cnt_reg[selThr][4'(dataSlot - 5'(FIRST_CNT_IDX))][31:0];
      end
    end else begin
      addrOk = 1'b0;
    end
  end

  // two-cycle access: answer registered on the first access cycle
  always_comb begin
    pready_next = 1'b0;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (psel && penable && !pready_reg) begin
      pready_next = 1'b1;
      prdata_next = pwrite ? WORD_RESET : rdVal;
      pslverr_next = !addrOk;
    end
  end

  assign wrEn = psel && penable && pwrite && pready_reg && addrOk;

  always_comb begin
    logic vmMatch;
    logic globalEn;
    logic monEn;
    logic opcOk;
    logic qualOk;
    logic [CNT_W:0] sum;
    logic [3:0] m4;
    vmMatch = 1'b0;
    globalEn = 1'b0;
    monEn = 1'b0;
    opcOk = 1'b0;
    qualOk = 1'b0;
    sum = '0;
    m4 = 4'h0;
    cfg_next = cfg_reg;
    cnt_next = cnt_reg;
    ovf_next = ovf_reg;
    freeze_next = freeze_reg;
    up_next = up_reg;
    pp_next = pp_reg;
    defPp_next = defPp_reg;
    opmMask_next = opmMask_reg;
    opmMatch_next = opmMatch_reg;
    iamEn_next = iamEn_reg;
    opmEn_next = opmEn_reg;
    damAddrEn_next = damAddrEn_reg;
    damType_next = damType_reg;
    countEnable_next = '0;

    // software writes first, so hardware sets below win over clears
    if (wrEn) begin
      if (wordIdx == IDX_STATUS0) begin // see [RQ20]
        freeze_next[selThr] = pwdata[STAT_FREEZE_BIT];
        ovf_next[selThr] = pwdata[STAT_OVF_LSB +: MONS];
      end else if (wordIdx >= IDX_CFG_FIRST && wordIdx <= IDX_CFG_LAST) begin
        m4 = cfgSlot[3:0];
        cfg_next[selThr][m4].privilegeLevelMask = pwdata[CFG_PLM_LSB +: 4];
        cfg_next[selThr][m4].systemMonitorSelect = pwdata[CFG_PM_BIT];
        cfg_next[selThr][m4].virtStateMask = pwdata[CFG_VM_LSB +: 2];
        cfg_next[selThr][m4].countHaltedQualifier = pwdata[CFG_CH_BIT];
        cfg_next[selThr][m4].qual = pwdata[CFG_QUAL_BIT];
        cfg_next[selThr][m4].opmSel = pwdata[CFG_OPM_SEL_BIT];
      end else if (wordIdx == IDX_OPM0_MSK) begin // see [RQ16]
        opmMask_next[selThr][0] = pwdata;
      end else if (wordIdx == IDX_OPM0_MAT) begin
        opmMatch_next[selThr][0] = pwdata;
      end else if (wordIdx == IDX_OPM1_MSK) begin
        opmMask_next[selThr][1] = pwdata;
      end else if (wordIdx == IDX_OPM1_MAT) begin
        opmMatch_next[selThr][1] = pwdata;
      end else if (wordIdx == IDX_IAM_CFG) begin
        iamEn_next[selThr] = pwdata[IAM_EN_BIT];
      end else if (wordIdx == IDX_OPM_CFG) begin
        opmEn_next[selThr] = {pwdata[OPM_EN1_BIT], pwdata[OPM_EN0_BIT]};
      end else if (wordIdx == IDX_DAM_CFG) begin
        damAddrEn_next[selThr] = pwdata[DAM_ADDR_EN_BIT];
        damType_next[selThr] = pwdata[DAM_TYPE_LSB +: 4];
      end else if (wordIdx == IDX_DEF_CTRL) begin
        defPp_next[selThr] = pwdata[DEF_PP_BIT];
      end
      // status view of the global enables ignores writes, see [RQ6]
    end

    for (int t = 0; t < THREADS; t++) begin
      // user enable is free to application code, see [RQ5]
      if (thrIn[t].setUserMask) begin
        up_next[t] = 1'b1;
      end else if (thrIn[t].resetUserMask) begin
        up_next[t] = 1'b0;
      end
      // delivery overrides a system mask instruction in the same cycle, see [RQ4]
      if (thrIn[t].intrDeliver) begin
        pp_next[t] = defPp_reg[t];
      end else if (thrIn[t].currentPrivLevel == 2'b00) begin // see [RQ6]
        if (thrIn[t].setSystemMask) begin
          pp_next[t] = 1'b1;
        end else if (thrIn[t].resetSystemMask) begin
          pp_next[t] = 1'b0;
        end
      end

      for (int m = 0; m < MONS; m++) begin
        // evaluated on this thread's own state only, see [RQ12]
        vmMatch = cfg_reg[t][m].virtStateMask[thrIn[t].virtMachineState] ||
                  (cfg_reg[t][m].virtStateMask == 2'b00); // see [RQ7] [RQ18]
        globalEn = cfg_reg[t][m].systemMonitorSelect ?
                   pp_reg[t] : up_reg[t]; // see [RQ2] [RQ3]
        monEn = !freeze_reg[t] &&
                cfg_reg[t][m].privilegeLevelMask[thrIn[t].currentPrivLevel] &&
                vmMatch && globalEn &&
                (!thrIn[t].halted ||
                 cfg_reg[t][m].countHaltedQualifier); // see [RQ1] [RQ8] [RQ19]
        opcOk = !opmEn_reg[t][cfg_reg[t][m].opmSel] ||
                ((thrIn[t].opcode & opmMask_reg[t][cfg_reg[t][m].opmSel]) ==
                 (opmMatch_reg[t][cfg_reg[t][m].opmSel] &
                  opmMask_reg[t][cfg_reg[t][m].opmSel])); // see [RQ16]
        // no instruction set term exists in this chain, see [RQ14]
        qualOk = !cfg_reg[t][m].qual ||
                 ((!iamEn_reg[t] || thrIn[t].instrRangeHit) && // see [RQ15]
                  opcOk &&
                  (!thrIn[t].memOp ||
                   ((!damAddrEn_reg[t] || thrIn[t].dataRangeHit) &&
                    (damType_reg[t] == 4'h0 ||
                     (damType_reg[t] & thrIn[t].refType) != 4'h0))));
                     // see [RQ17]
        countEnable_next[t][m] = monEn;
        if (events[t][m] && monEn && qualOk) begin
          sum = {1'b0, cnt_reg[t][m]} + {{CNT_W{1'b0}}, 1'b1};
          cnt_next[t][m] = sum[CNT_W-1:0];
          if (sum[CNT_W]) begin
            ovf_next[t][m] = 1'b1;
            freeze_next[t] = 1'b1; // see [RQ20]
          end
        end
      end
    end

    // a data write replaces the written half of any increment of the same cycle
    if (wrEn && wordIdx >= IDX_DATA_BASE + 9'(2 * FIRST_CNT_IDX) &&
        wordIdx <= IDX_DATA_LAST) begin
      m4 = 4'(dataSlot - 5'(FIRST_CNT_IDX));
      if (dataHi) begin
        cnt_next[selThr][m4][CNT_W-1:32] = pwdata[CNT_HI_W-1:0];
      end else begin
        cnt_next[selThr][m4][31:0] = pwdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_reg <= '0;
      cnt_reg <= '0;
      ovf_reg <= '0;
      freeze_reg <= '0;
      up_reg <= '0;
      pp_reg <= '0;
      defPp_reg <= '0;
      opmMask_reg <= '0;
      opmMatch_reg <= '0;
      iamEn_reg <= '0;
      opmEn_reg <= '0;
      damAddrEn_reg <= '0;
      damType_reg <= '0;
      countEnable <= '0;
      pready_reg <= 1'b0;
      prdata_reg <= WORD_RESET;
      pslverr_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      cnt_reg <= cnt_next;
      ovf_reg <= ovf_next;
      freeze_reg <= freeze_next;
      up_reg <= up_next;
      pp_reg <= pp_next;
      defPp_reg <= defPp_next;
      opmMask_reg <= opmMask_next;
      opmMatch_reg <= opmMatch_next;
      iamEn_reg <= iamEn_next;
      opmEn_reg <= opmEn_next;
      damAddrEn_reg <= damAddrEn_next;
      damType_reg <= damType_next;
      countEnable <= countEnable_next;
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

endmodule : pmq_count_qualifier

// ### include/pmq_pkg.sv
/*
  Constants, register map and carrier types for the monitor count
  qualifier. Assumes one core clock and a 32-bit APB master.
*/
package pmq_pkg;
  localparam int THREADS = 2;
  localparam int MONS = 16;
  localparam int CNT_W = 48;
  localparam int OPC_W = 32;
  localparam int ADDR_W = 12;
  localparam int FIRST_CNT_IDX = 4;

  // byte address: bit 11 selects the thread copy, bits 10:2 the word
  localparam int THREAD_BIT = 11;
  localparam logic [8:0] IDX_STATUS0 = 9'h000;
  localparam logic [8:0] IDX_STATUS3 = 9'h003;
  localparam logic [8:0] IDX_CFG_FIRST = 9'h004;
  localparam logic [8:0] IDX_CFG_LAST = 9'h013;
  localparam logic [8:0] IDX_OPM0_MSK = 9'h028;
  localparam logic [8:0] IDX_OPM0_MAT = 9'h029;
  localparam logic [8:0] IDX_OPM1_MSK = 9'h02A;
  localparam logic [8:0] IDX_OPM1_MAT = 9'h02B;
  localparam logic [8:0] IDX_IAM_CFG = 9'h030;
  localparam logic [8:0] IDX_OPM_CFG = 9'h031;
  localparam logic [8:0] IDX_DAM_CFG = 9'h032;
  localparam logic [8:0] IDX_PROC_STATUS = 9'h03C;
  localparam logic [8:0] IDX_DEF_CTRL = 9'h03D;
  // counter data: word DATA_BASE + 2*index (low), +1 (high)
  localparam logic [8:0] IDX_DATA_BASE = 9'h100;
  localparam logic [8:0] IDX_DATA_LAST = 9'h127;

  localparam int STAT_FREEZE_BIT = 0;
  localparam int STAT_OVF_LSB = 4;
  localparam int CFG_PLM_LSB = 0;
  localparam int CFG_PM_BIT = 6;
  localparam int CFG_VM_LSB = 8;
  localparam int CFG_CH_BIT = 10;
  localparam int CFG_QUAL_BIT = 12;
  localparam int CFG_OPM_SEL_BIT = 13;
  localparam int IAM_EN_BIT = 0;
  localparam int OPM_EN0_BIT = 0;
  localparam int OPM_EN1_BIT = 1;
  localparam int DAM_ADDR_EN_BIT = 0;
  localparam int DAM_TYPE_LSB = 4;
  localparam int PS_UP_BIT = 0;
  localparam int PS_PP_BIT = 1;
  localparam int DEF_PP_BIT = 0;
  localparam int CNT_HI_W = CNT_W - 32;

  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  typedef struct packed {
    logic opmSel;
    logic qual;
    logic countHaltedQualifier;
    logic [1:0] virtStateMask;
    logic systemMonitorSelect;
    logic [3:0] privilegeLevelMask;
  } pmq_mon_cfg_t;

  typedef struct packed {
    logic [1:0] currentPrivLevel;
    logic virtMachineState;
    logic halted;
    logic intrDeliver;
    logic setUserMask;
    logic resetUserMask;
    logic setSystemMask;
    logic resetSystemMask;
    logic instrRangeHit;
    logic [OPC_W-1:0] opcode;
    logic memOp;
    logic dataRangeHit;
    logic [3:0] refType;
  } pmq_thr_in_t;
endpackage : pmq_pkg

// ### test/pmq_count_qualifier_chk.sv
/*
  Checker for the monitor count qualifier: APB answer timing, the
  global enable view and the gating of count enables.
  Assumes one clock and a view of the top ports only.
*/
`timescale 1ns/100ps
module pmq_count_qualifier_chk
  import pmq_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire pmq_thr_in_t [THREADS-1:0] thrIn,
  input wire logic [THREADS-1:0][MONS-1:0] events,
  input wire logic [THREADS-1:0][MONS-1:0] countEnable
);
  logic [1:0] userEn_reg, userEn_next, sysEn_reg, sysEn_next;
  logic [1:0] defPp_reg, defPp_next, frz_reg, frz_next, gateOk, anyEn;
  logic wrDone;
  assign wrDone = psel && penable && pready && pwrite && !pslverr;
  assign gateOk = (userEn_reg | sysEn_reg) & ~frz_reg;
  assign anyEn = {|countEnable[1], |countEnable[0]};
  // overflow freeze is not mirrored: a missed freeze only weakens the check
  always_comb begin
    {userEn_next, sysEn_next} = {userEn_reg, sysEn_reg};
    {defPp_next, frz_next} = {defPp_reg, frz_reg};
    for (int t = 0; t < THREADS; t++) begin
      if (thrIn[t].setUserMask) userEn_next[t] = 1'b1;
      else if (thrIn[t].resetUserMask) userEn_next[t] = 1'b0;
      if (thrIn[t].intrDeliver) sysEn_next[t] = defPp_reg[t];
      else if (thrIn[t].currentPrivLevel == 2'h0) begin
        if (thrIn[t].setSystemMask) sysEn_next[t] = 1'b1;
        else if (thrIn[t].resetSystemMask) sysEn_next[t] = 1'b0;
      end
    end
    if (wrDone && paddr[10:2] == IDX_DEF_CTRL)
      defPp_next[paddr[11]] = pwdata[DEF_PP_BIT];
    if (wrDone && paddr[10:2] == IDX_STATUS0)
      frz_next[paddr[11]] = pwdata[STAT_FREEZE_BIT];
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      {userEn_reg, sysEn_reg, defPp_reg, frz_reg} <= 8'h00;
    end else begin
      {userEn_reg, sysEn_reg} <= {userEn_next, sysEn_next};
      {defPp_reg, frz_reg} <= {defPp_next, frz_next};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  property p_ready_lat; s_setup ##1 s_access |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_ready; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_misalign;
    (psel && !penable && paddr[1:0] != 2'h0) ##1 s_access |=> pslverr;
  endproperty
  property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
  property p_reset_quiet; $fell(reset) |-> countEnable == '0 && !pready;
  endproperty
  property p_psr_view;
    logic [1:0] v;
    (psel && penable && !pready && !pwrite && paddr == {paddr[11],
      IDX_PROC_STATUS, 2'h0}, v = {sysEn_reg[paddr[11]],
      userEn_reg[paddr[11]]}) |=> prdata == {30'h0, v};
  endproperty
  property p_gate; (anyEn & ~$past(gateOk)) == 2'h0; endproperty
  a_ready_lat: assert property (p_ready_lat)
    else $error("no answer in second access cycle");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready or with data");
  a_misalign: assert property (p_misalign)
    else $error("misaligned access not refused");
  a_wr_zero: assert property (p_wr_zero)
    else $error("read data not zero on write");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  a_psr_view: assert property (p_psr_view)
    else $error("global enable view wrong");
  a_gate: assert property (p_gate)
    else $error("enable without global enable or while frozen");
endmodule : pmq_count_qualifier_chk

bind pmq_count_qualifier pmq_count_qualifier_chk u_chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .thrIn(thrIn), .events(events),
  .countEnable(countEnable)
);

// ### test/pmq_count_qualifier_tb_top.sv
/*
  Self-checking bench for the monitor count qualifier: registers,
  global enables, random enable checks, counting, freeze, qualifiers.
  Assumes the bound checker and a 40 MHz clock.
*/
`timescale 1ns/100ps
module pmq_count_qualifier_tb_top import pmq_pkg::*;;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, erv;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdv;
  pmq_thr_in_t [THREADS-1:0] thrIn = '0;
  logic [THREADS-1:0][MONS-1:0] events = '0, countEnable;
  logic [1:0] upT = 2'h0, ppT = 2'h0;
  int nMismatch = 0, compares = 0;
  pmq_count_qualifier u_dut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .thrIn(thrIn),
    .events(events), .countEnable(countEnable));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] x, g);
    compares++;
    if (g !== x) begin
      nMismatch++;
      $display("FAIL %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite} <= {2'b10, w};
    {paddr, pwdata} <= {a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (n == 16) begin
      nMismatch++;
      tally_and_finish();
    end
    {rdv, erv} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wr(input logic t, input logic [8:0] i, input logic [31:0] d);
    apb(1'b1, {t, i, 2'b00}, d);
  endtask : wr
  task automatic rd(input string nm, input logic t, input logic [8:0] i,
    input logic [31:0] x);
    apb(1'b0, {t, i, 2'b00}, 32'h0);
    chk(nm, x, rdv);
  endtask : rd
  // order: interruption, set user, reset user, set system, reset system
  task automatic pulse(input logic t, input logic [4:0] p);
    @(posedge clk);
    {thrIn[t].intrDeliver, thrIn[t].setUserMask, thrIn[t].resetUserMask,
      thrIn[t].setSystemMask, thrIn[t].resetSystemMask} <= p;
    @(posedge clk);
    {thrIn[t].intrDeliver, thrIn[t].setUserMask, thrIn[t].resetUserMask,
      thrIn[t].setSystemMask, thrIn[t].resetSystemMask} <= 5'h00;
  endtask : pulse
  task automatic lv(input logic t, input logic [1:0] c, input logic v, h);
    @(posedge clk);
    {thrIn[t].currentPrivLevel, thrIn[t].virtMachineState} <= {c, v};
    thrIn[t].halted <= h;
  endtask : lv
  // events go to both threads; thread 0's monitor 3 is configured to zero
  task automatic ev(input int m, input int n);
    repeat (n) begin
      @(posedge clk);
      {events[0][m], events[1][m]} <= 2'b11;
    end
    @(posedge clk);
    {events[0][m], events[1][m]} <= 2'b00;
  endtask : ev
  function automatic logic expEn(input logic [31:0] c, input logic [1:0] l,
    input logic v, h, u, p);
    logic vmOk;
    vmOk = c[CFG_VM_LSB + v] || c[9:8] == 2'h0;
    return c[l] && vmOk && (c[CFG_PM_BIT] ? p : u) && (!h || c[CFG_CH_BIT]);
  endfunction : expEn
  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    tally_and_finish();
  end
  initial begin : main
    logic t;
    logic [31:0] c;
    logic [3:0] p, q;
    logic [1:0] l;
    logic v, h;
    int m, n;
    void'($urandom(39096));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      rd("status", k[0], IDX_STATUS0, 32'h0);
      rd("config", k[0], IDX_CFG_LAST, 32'h0);
      rd("data", k[0], IDX_DATA_LAST, 32'h0);
    end
    apb(1'b0, {1'b0, 9'h03E, 2'b00}, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, erv});
    apb(1'b1, 12'h012, 32'h0000_000F);
    chk("misaligned error", 32'h1, {31'h0, erv});
    rd("config kept", 1'b0, IDX_CFG_FIRST, 32'h0);
    pulse(1'b0, 5'b01000);
    rd("view", 1'b0, IDX_PROC_STATUS, 32'h1);
    rd("view other", 1'b1, IDX_PROC_STATUS, 32'h0);
    lv(1'b0, 2'h1, 1'b0, 1'b0);
    pulse(1'b0, 5'b00010);
    rd("view", 1'b0, IDX_PROC_STATUS, 32'h1);
    lv(1'b0, 2'h0, 1'b0, 1'b0);
    pulse(1'b0, 5'b00010);
    rd("view", 1'b0, IDX_PROC_STATUS, 32'h3);
    pulse(1'b0, 5'b10010);
    rd("view", 1'b0, IDX_PROC_STATUS, 32'h1);
    wr(1'b0, IDX_DEF_CTRL, 32'h1);
    pulse(1'b0, 5'b10001);
    rd("view", 1'b0, IDX_PROC_STATUS, 32'h3);
    pulse(1'b0, 5'b00101);
    rd("view", 1'b0, IDX_PROC_STATUS, 32'h0);
    for (int k = 0; k < 40; k++) begin
      {t, m, c, p} = {1'($urandom), $urandom_range(15), $urandom, 4'($urandom)};
      c = c & 32'h0000_074F;
      wr(t, 9'(IDX_CFG_FIRST + m), c);
      lv(t, 2'h0, 1'b0, 1'b0);
      pulse(t, {1'b0, p});
      upT[t] = p[3] ? 1'b1 : (p[2] ? 1'b0 : upT[t]);
      ppT[t] = p[1] ? 1'b1 : (p[0] ? 1'b0 : ppT[t]);
      {l, v, h} = 4'($urandom);
      lv(t, l, v, h);
      repeat (2) @(posedge clk);
      #1 chk("enable", {31'h0, expEn(c, l, v, h, upT[t], ppT[t])},
        {31'h0, countEnable[t][m]});
      // random levels cover the halt and virtual terms
    end
    wr(1'b0, 9'h007, 32'h0);
    wr(1'b1, 9'h007, 32'h0000_000F);
    pulse(1'b1, 5'b01000);
    lv(1'b1, 2'h0, 1'b0, 1'b0);
    ev(3, 5);
    rd("count", 1'b1, 9'h10E, 32'h5);
    rd("count other", 1'b0, 9'h10E, 32'h0);
    wr(1'b1, 9'h10E, 32'hFFFF_FFFF);
    wr(1'b1, 9'h10F, 32'h0000_FFFF);
    ev(3, 1);
    rd("overflow", 1'b1, IDX_STATUS0, 32'h0000_0081);
    rd("wrap high", 1'b1, 9'h10F, 32'h0);
    ev(3, 2);
    rd("frozen", 1'b1, 9'h10E, 32'h0);
    #1 chk("frozen enable", 32'h0, {31'h0, countEnable[1][3]});
    wr(1'b1, IDX_STATUS0, 32'h0);
    ev(3, 1);
    rd("resumed", 1'b1, 9'h10E, 32'h1);
    // qualifiers go to thread 1 only; no mode counts both
    wr(1'b1, IDX_IAM_CFG, 32'h1);
    wr(1'b1, IDX_OPM_CFG, 32'h1);
    wr(1'b1, IDX_OPM0_MSK, 32'h0000_00FF);
    wr(1'b1, IDX_OPM0_MAT, 32'h0000_005A);
    wr(1'b1, IDX_DAM_CFG, 32'h1);
    wr(1'b1, 9'h007, 32'h0000_100F);
    n = 1;
    // bits: memory op, data range hit, address hit, opcode matches
    foreach (c[k]) if (k < 5) begin
      q = k[2] ? 4'hF : (k[1] ? (k[0] ? 4'hB : 4'h3) : (k[0] ? 4'h2 : 4'h1));
      @(posedge clk);
      {thrIn[1].memOp, thrIn[1].dataRangeHit, thrIn[1].instrRangeHit} <= q[3:1];
      thrIn[1].opcode <= q[0] ? 32'h0000_005A : 32'h0000_005B;
      ev(3, 1);
      n = n + int'(q[1] && q[0] && (!q[3] || q[2]));
      rd("qualified", 1'b1, 9'h10E, 32'(n));
    end
    tally_and_finish();
  end
endmodule : pmq_count_qualifier_tb_top
